// File: logic/prescaled_down_counter_timer.sv
// prescaled 8-bit down-counter timer with APB registers and interrupt request
// assumes APB master on i_clk, timer pin synchronous-sampled through three flops
// Function
// R01: loadable 8-bit counter decrements per source tick or prescaler output
// R02: counter reaching zero sets request flag, control bit 7
// R03: mask bit 6 set blocks timer interrupt to cpu
// R04: cpu mask holds pending interrupt; taken once mask clears
// R05: on accept, stack cpu state then fetch vector from $FF8/$FF9
// R06: request flag stays set until software clears it
// R07: timer and second external irq share one vector; software checks both
// R08: external source counts on each rising pin transition
// R09: pin change reaches prescaler three machine cycles later
// R10: pin must be seen low before another rising edge counts
// R11: internal clock source gated by timer pin level
// R12: source selection is a build-time option
// R13: host should tie pin high for ungated internal clocking
// R14: prescaler divides by power of two up to 128, build-time fixed
// R15: writing one to bit 3 clears prescaler; bit reads zero
// R16: reset clears request flag
// R17: reset sets mask flag
// R18: control bits 5,4,2,1,0 read as ones
// R19: counter wraps $00 to $FF; reads do not disturb counting
// R20: reset sets prescaler and counter to all ones
// R21: request output is flag and not mask, held as level
// R22: timer pin synchronised before edge or level detection
//
// Our own choices: the APB slave port and the address map.
module prescaled_down_counter_timer
   import tmr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic i_timer_pin,
   input wire logic i_second_external_irq,
   input wire logic i_cpu_irq_mask,
   input wire logic i_irq_ack,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   output logic o_timer_irq,
   output logic o_shared_irq,
   output logic o_stack_push,
   output logic o_vec_fetch,
   output logic [11:0] o_vec_addr
);
   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   apb_req_t req;
   logic wr_ctrl, wr_cnt, acc;
   assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr,
                  pwdata: i_pwdata};
   assign acc = req.psel && req.penable;
   assign wr_ctrl = acc && req.pwrite && (req.paddr == ADDR_CONTROL);
   assign wr_cnt = acc && req.pwrite && (req.paddr == ADDR_COUNT);

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == ADDR_CONTROL) || (a == ADDR_COUNT) || (a == ADDR_IRQ2);
   endfunction

   // ---------------------------------------------------------------
   // pin synchroniser and pipeline
   // ---------------------------------------------------------------
   logic pin_s1_q, pin_s2_q, pin_s3_q;
   logic armed_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= i_timer_pin; // R22
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q; // R09
      end
   end

   // no arming until the pin pipeline holds real samples
   logic [2:0] fill_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fill_q <= '0;
      end else begin
         fill_q <= {fill_q[1:0], 1'b1};
      end
   end

   // re-arm only after a low level has been seen
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         armed_q <= 1'b0;
      end else if (fill_q[$left(fill_q)] && !pin_s3_q) begin
         armed_q <= 1'b1; // R10
      end else if (armed_q) begin
         armed_q <= 1'b0;
      end
   end

   logic src_tick;
   always_comb begin
      if (SRC_SELECT == SRC_EXTERNAL) begin // R12
         src_tick = pin_s3_q && armed_q; // R08 R09 R10
      end else begin
         src_tick = pin_s3_q; // R11
      end
   end

   // ---------------------------------------------------------------
   // prescaler
   // ---------------------------------------------------------------
   logic [6:0] presc_q;
   logic presc_out;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         presc_q <= PRESC_RESET; // R20
      end else if (wr_ctrl && req.pwdata[BIT_PSCLR]) begin
         presc_q <= PRESC_RESET; // R15
      end else if (src_tick) begin
         presc_q <= presc_q - 7'h01;
      end
   end
   generate
      if (PRESC_LOG2 == 0) begin : g_nodiv
         assign presc_out = src_tick;
      end else begin : g_div
         // all low bits at zero and about to roll: one tick in 2^n
         assign presc_out = src_tick &&
                            (presc_q[PRESC_LOG2-1:0] == '0); // R14
      end
   endgenerate

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   function automatic logic [7:0] dec8(input logic [7:0] v);
      dec8 = v - 8'h01;
   endfunction

   logic [7:0] count_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_q <= COUNT_RESET; // R20
      end else if (wr_cnt) begin
         count_q <= req.pwdata[7:0]; // R01
      end else if (presc_out) begin
         count_q <= dec8(count_q); // R01 R19
      end
   end
   logic hit_zero;
   assign hit_zero = presc_out && !wr_cnt && (dec8(count_q) == COUNT_ZERO);

   // ---------------------------------------------------------------
   // control flags
   // ---------------------------------------------------------------
   logic req_q, mask_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_q <= 1'b0; // R16
      end else if (hit_zero) begin
         req_q <= 1'b1; // R02
      end else if (wr_ctrl && !req.pwdata[BIT_REQ]) begin
         req_q <= 1'b0; // R06
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mask_q <= 1'b1; // R17
      end else if (wr_ctrl) begin
         mask_q <= req.pwdata[BIT_MASK];
      end
   end

   // ---------------------------------------------------------------
   // interrupt outputs and service sequence
   // ---------------------------------------------------------------
   logic irq_d;
   assign irq_d = req_q && !mask_q; // R03 R21
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_timer_irq <= 1'b0;
         o_shared_irq <= 1'b0;
      end else begin
         o_timer_irq <= irq_d; // R21
         o_shared_irq <= irq_d || i_second_external_irq; // R07
      end
   end

   svc_state_t st_q;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q <= ST_IDLE;
         o_stack_push <= 1'b0;
         o_vec_fetch <= 1'b0;
         o_vec_addr <= VEC_HI_ADDR;
      end else begin
         o_stack_push <= 1'b0;
         o_vec_fetch <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (o_shared_irq && !i_cpu_irq_mask && i_irq_ack) begin // R04
                  st_q <= ST_PUSH;
                  o_stack_push <= 1'b1; // R05
               end
            end
            ST_PUSH: begin
               st_q <= ST_VEC;
               o_vec_fetch <= 1'b1;
               o_vec_addr <= VEC_HI_ADDR; // R05
            end
            ST_VEC: begin
               st_q <= ST_IDLE;
               o_vec_fetch <= 1'b1;
               o_vec_addr <= VEC_LO_ADDR; // R05
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   apb_rsp_t rsp_d;
   logic [7:0] ctrl_rd;
   always_comb begin
      ctrl_rd = CTRL_UNUSED_ONES; // R18
      ctrl_rd[BIT_REQ] = req_q;
      ctrl_rd[BIT_MASK] = mask_q;
      ctrl_rd[BIT_PSCLR] = 1'b0; // R15
      rsp_d.pready = req.psel && !req.penable;
      rsp_d.pslverr = req.psel && !req.penable && !mapped(req.paddr);
      rsp_d.prdata = 32'h00000000;
      if (req.psel && !req.penable && !req.pwrite) begin
         if (req.paddr == ADDR_CONTROL) begin
            rsp_d.prdata = {24'h000000, ctrl_rd};
         end else if (req.paddr == ADDR_COUNT) begin
            rsp_d.prdata = {24'h000000, count_q}; // R19
         end else if (req.paddr == ADDR_IRQ2) begin
            rsp_d.prdata = {31'h00000000, i_second_external_irq};
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end else begin
         o_pready <= rsp_d.pready;
         o_pslverr <= rsp_d.pslverr;
         o_prdata <= rsp_d.prdata;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   // ---------------------------------------------------------------
   // checks: request flag, mask and interrupt levels
   // ---------------------------------------------------------------
   chk_zero_sets_flag: assert property (hit_zero |=> req_q) // R02
      else $error("zero reach did not set request");
   chk_flag_holds: assert property (req_q && !wr_ctrl |=> req_q) // R06
      else $error("request flag dropped without write");
   chk_flag_clears: assert property ( // R06
      wr_ctrl && !req.pwdata[BIT_REQ] && !hit_zero |=> !req_q)
      else $error("request flag not cleared by write");
   chk_mask_follows: assert property ( // R03
      wr_ctrl |=> mask_q == $past(req.pwdata[BIT_MASK]))
      else $error("mask flag did not take written value");
   chk_mask_blocks_irq: assert property (mask_q |=> !o_timer_irq) // R03
      else $error("masked irq seen");
   chk_irq_level: assert property (req_q && !mask_q |=> o_timer_irq) // R21
      else $error("irq level not driven");
   chk_irq_off_clear: assert property (!req_q |=> !o_timer_irq) // R21
      else $error("irq seen without request");
   chk_shared_merge: assert property (i_second_external_irq |=> o_shared_irq) // R07
      else $error("second irq missing from shared request");
   chk_shared_timer: assert property (irq_d |=> o_shared_irq) // R07
      else $error("timer irq missing from shared request");

   // ---------------------------------------------------------------
   // checks: register readback
   // ---------------------------------------------------------------
   chk_psclr_reads_zero: assert property ( // R15 R18
      o_pready && !o_pslverr && !$past(req.pwrite) && $past(req.paddr) == ADDR_CONTROL
      |-> !o_prdata[BIT_PSCLR] && ((o_prdata[7:0] & CTRL_UNUSED_ONES) == CTRL_UNUSED_ONES))
      else $error("control readback bits wrong");
   chk_readback_count: assert property ( // R19
      o_pready && !$past(req.pwrite) && $past(req.paddr) == ADDR_COUNT
      |-> o_prdata == {24'h000000, $past(count_q)})
      else $error("counter readback wrong");

   // ---------------------------------------------------------------
   // checks: pin path, prescaler and counter
   // ---------------------------------------------------------------
   chk_pin_delay: assert property ( // R09 R22
      $past(i_arst_n, 3) && $past(i_arst_n, 2) && $past(i_arst_n)
      |-> pin_s3_q == $past(i_timer_pin, 3))
      else $error("timer pin delay wrong");
   chk_gate_stops: assert property ( // R11 R14
      !src_tick && !(wr_ctrl && req.pwdata[BIT_PSCLR]) |=> $stable(presc_q))
      else $error("prescaler moved without a source tick");
   chk_psclr_clears: assert property ( // R15
      wr_ctrl && req.pwdata[BIT_PSCLR] |=> presc_q == PRESC_RESET)
      else $error("prescaler not cleared");
   chk_count_load: assert property ( // R01
      wr_cnt |=> count_q == $past(req.pwdata[7:0]))
      else $error("counter load lost");
   chk_count_steps: assert property ( // R01 R19
      presc_out && !wr_cnt |=> count_q == dec8($past(count_q)))
      else $error("counter step wrong");
   chk_count_holds: assert property ( // R19
      !presc_out && !wr_cnt |=> $stable(count_q))
      else $error("counter moved without a prescaler output");
   chk_count_wraps: assert property ( // R19
      presc_out && !wr_cnt && count_q == COUNT_ZERO |=> count_q == COUNT_RESET)
      else $error("counter did not wrap");

   // ---------------------------------------------------------------
   // checks: service sequence
   // ---------------------------------------------------------------
   chk_cpu_mask_holds: assert property ( // R04
      i_cpu_irq_mask && st_q == ST_IDLE |=> !o_stack_push)
      else $error("serviced while cpu masked");
   chk_push_once: assert property (o_stack_push |=> !o_stack_push) // R05
      else $error("stack push longer than one cycle");
   chk_vector_order: assert property ( // R05
      o_stack_push |=> o_vec_fetch && o_vec_addr == VEC_HI_ADDR
      ##1 o_vec_fetch && o_vec_addr == VEC_LO_ADDR)
      else $error("vector fetch order wrong");

   cov_zero_hit: cover property (hit_zero);
   cov_service: cover property (o_stack_push ##2 o_vec_fetch);
   cov_wrap: cover property (count_q == COUNT_ZERO ##[1:300] count_q == COUNT_RESET);
   cov_psclr: cover property (wr_ctrl && req.pwdata[BIT_PSCLR]);
   cov_second_only: cover property (o_shared_irq && !o_timer_irq);
endmodule

// File: logic/tmr_pkg.sv
// timer package: register map, control bit positions, reset values, option codes
// assumes a 32-bit APB master and a 20 MHz system clock
package tmr_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_COUNT = 12'h004;
   localparam logic [11:0] ADDR_IRQ2 = 12'h008;
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int BIT_REQ = 7;
   localparam int BIT_MASK = 6;
   localparam int BIT_PSCLR = 3;
   localparam logic [7:0] CTRL_UNUSED_ONES = 8'h37;
   localparam logic [7:0] COUNT_RESET = 8'hFF;
   localparam logic [6:0] PRESC_RESET = 7'h7F;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   // ---------------------------------------------------------------
   // build-time options
   // ---------------------------------------------------------------
   localparam logic SRC_EXTERNAL = 1'b0;
   localparam logic SRC_INTERNAL = 1'b1;
   localparam int PRESC_MAX_LOG2 = 7;
   // bits of the prescaler feeding the counter: 0 means divide by one
   localparam int PRESC_LOG2 = 7;
   localparam logic SRC_SELECT = SRC_INTERNAL;
   // ---------------------------------------------------------------
   // vector and bus types
   // ---------------------------------------------------------------
   localparam logic [11:0] VEC_HI_ADDR = 12'hFF8;
   localparam logic [11:0] VEC_LO_ADDR = 12'hFF9;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PUSH,
      ST_VEC
   } svc_state_t;
endpackage

// File: verification/cpu_ack_model.sv
// cpu side model: acknowledges a pending shared interrupt request
// assumes a level request and a one-cycle stack push from the timer
module cpu_ack_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_irq,
   input wire logic i_push,
   input wire logic i_enable,
   output logic o_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   // ack drops for a cycle after each push; handler then polls both sources
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ack <= 1'h0;
      end else begin
         o_ack <= i_enable & i_irq & ~i_push;
      end
   end
endmodule

// File: verification/prescaled_down_counter_timer_tb.sv
// testbench: register table, counting, wrap, masking and service sequence
// assumes the internal gated source, divide by 128 and one wait-free apb slave
module prescaled_down_counter_timer_tb
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 1'h0, i_arst_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   logic i_timer_pin = 1'h0, i_second_external_irq = 1'h0, i_cpu_irq_mask = 1'h1;
   logic i_irq_ack, ack_en = 1'h0, er;
   logic o_pready, o_pslverr, o_timer_irq, o_shared_irq, o_stack_push, o_vec_fetch;
   logic [31:0] o_prdata, rd;
   logic [11:0] o_vec_addr;
   int failures = 0, n_compared = 0, n;
   typedef struct packed {
      logic wr;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] exp;
      logic err;
   } row_t;
   row_t rows [9] = '{'{1'h0, ADDR_CONTROL, 32'h0, 32'h77, 1'h0},
      '{1'h0, ADDR_COUNT, 32'h0, 32'hFF, 1'h0}, '{1'h1, ADDR_COUNT, 32'h5A, 32'h0, 1'h0},
      '{1'h0, ADDR_COUNT, 32'h0, 32'h5A, 1'h0}, '{1'h1, ADDR_CONTROL, 32'h08, 32'h0, 1'h0},
      '{1'h0, ADDR_CONTROL, 32'h0, 32'h37, 1'h0}, '{1'h1, 12'h00C, 32'hFF, 32'h0, 1'h1},
      '{1'h0, 12'h00C, 32'h0, 32'h0, 1'h1}, '{1'h0, ADDR_CONTROL, 32'h0, 32'h37, 1'h0}};

   prescaled_down_counter_timer DUT (.i_clk, .i_arst_n, .i_psel, .i_penable, .i_pwrite,
      .i_paddr, .i_pwdata, .i_timer_pin, .i_second_external_irq, .i_cpu_irq_mask,
      .i_irq_ack, .o_pready, .o_pslverr, .o_prdata, .o_timer_irq, .o_shared_irq,
      .o_stack_push, .o_vec_fetch, .o_vec_addr);
   cpu_ack_model cpu (.i_clk, .i_arst_n, .i_irq(o_shared_irq), .i_push(o_stack_push),
      .i_enable(ack_en), .o_ack(i_irq_ack));

   always #25 i_clk = ~i_clk;

   // -------------------------------------------------------------
   // bus and check tasks
   // -------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_psel <= 1'h1;
      i_penable <= 1'h0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'h1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge i_clk);
      failures++;
      end_sim;
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (10) @(posedge i_clk);
      i_arst_n <= 1'h1;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         chk("slverr", 32'(er), 32'(rows[i].err));
         if (!rows[i].wr) chk("rdata", rd, rows[i].exp);
      end
      apb(1'h1, ADDR_CONTROL, 32'h48);
      apb(1'h1, ADDR_COUNT, 32'h01);
      i_timer_pin <= 1'h1;
      n = 0;
      do begin
         apb(1'h0, ADDR_CONTROL, 32'h0);
         n++;
      end while (rd[7] !== 1'h1 && n < 100);
      chk("request set", 32'(rd[BIT_REQ]), 32'h1);
      apb(1'h0, ADDR_COUNT, 32'h0);
      chk("count at zero", rd, 32'h00);
      chk("masked irq", 32'(o_timer_irq), 32'h0);
      repeat (130) @(posedge i_clk);
      apb(1'h0, ADDR_COUNT, 32'h0);
      chk("count wrap", rd, 32'hFF);
      i_timer_pin <= 1'h0;
      ack_en <= 1'h1;
      apb(1'h1, ADDR_CONTROL, 32'h80);
      repeat (10) @(posedge i_clk);
      chk("irq level", 32'(o_timer_irq), 32'h1);
      chk("held push", 32'(o_stack_push), 32'h0);
      i_cpu_irq_mask <= 1'h0;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_stack_push !== 1'h1 && n < 10);
      chk("push", 32'(o_stack_push), 32'h1);
      @(posedge i_clk);
      chk("fetch hi", {19'h0, o_vec_fetch, o_vec_addr}, {20'h1, VEC_HI_ADDR});
      @(posedge i_clk);
      chk("fetch lo", {19'h0, o_vec_fetch, o_vec_addr}, {20'h1, VEC_LO_ADDR});
      i_cpu_irq_mask <= 1'h1;
      apb(1'h0, ADDR_CONTROL, 32'h0);
      chk("flag kept", rd, 32'hB7);
      apb(1'h1, ADDR_CONTROL, 32'h40);
      apb(1'h0, ADDR_CONTROL, 32'h0);
      chk("flag cleared", rd, 32'h77);
      i_second_external_irq <= 1'h1;
      repeat (3) @(posedge i_clk);
      chk("shared irq", {30'h0, o_shared_irq, o_timer_irq}, 32'h2);
      apb(1'h0, ADDR_IRQ2, 32'h0);
      chk("second irq status", rd, 32'h1);
      apb(1'h1, ADDR_COUNT, 32'h33);
      apb(1'h1, ADDR_CONTROL, 32'h00);
      i_arst_n <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_arst_n <= 1'h1;
      apb(1'h0, ADDR_CONTROL, 32'h0);
      chk("ctrl after reset", rd, 32'h77);
      apb(1'h0, ADDR_COUNT, 32'h0);
      chk("count after reset", rd, 32'hFF);
      chk("vector after reset", {19'h0, o_vec_fetch, o_vec_addr}, {20'h0, VEC_HI_ADDR});
      end_sim;
   end
endmodule
